// [common/ebc_pkg.sv]
package ebc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_S0,
        ST_S1,
        ST_S2,
        ST_S3,
        ST_S4,
        ST_S5
    } bus_state_t;

    // Acknowledge pair {upper, lower}, active low
    localparam logic [1:0] ACK_NONE   = 2'h3;
    localparam logic [1:0] ACK_PORT8  = 2'h2;
    localparam logic [1:0] ACK_PORT16 = 2'h1;

    // Transfer length codes
    localparam logic [1:0] SIZE_BYTE  = 2'h1;
    localparam logic [1:0] SIZE_WORD  = 2'h2;
    localparam logic [1:0] SIZE_THREE = 2'h3;
    localparam logic [1:0] SIZE_LONG  = 2'h0;

    // Values after reset
    localparam logic       RST_STROBE_N = 1'h1;
    localparam logic       RST_RW       = 1'h1;
    localparam logic [2:0] RST_SYNC     = 3'h7;

    function automatic logic [1:0] size_code(input logic [2:0] rem);
        case (rem)
            3'h1:    size_code = SIZE_BYTE;
            3'h2:    size_code = SIZE_WORD;
            3'h3:    size_code = SIZE_THREE;
            default: size_code = SIZE_LONG;
        endcase
    endfunction

    function automatic logic [2:0] size_bytes(input logic [1:0] code);
        case (code)
            SIZE_BYTE:  size_bytes = 3'h1;
            SIZE_WORD:  size_bytes = 3'h2;
            SIZE_THREE: size_bytes = 3'h3;
            default:    size_bytes = 3'h4;
        endcase
    endfunction

endpackage

// [hdl/external_bus_cycle_sequencer.sv]
`timescale 1ns/1ps
module external_bus_cycle_sequencer #(
    parameter int ADDR_W = 24,
    parameter int FC_W   = 3
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst,
    // Operation request
    input  wire logic                         req_valid,
    output logic                              req_ready,
    input  wire logic                         req_write,
    input  wire logic                         req_lock,
    input  wire logic [1:0]                   req_size,
    input  wire logic [ADDR_W-1:0]            req_addr,
    input  wire logic [FC_W-1:0]              req_fc,
    input  wire logic [31:0]                  req_wdata,
    input  wire logic                         lock_release,
    // Operation result
    output logic                              op_done,
    output logic [31:0]                       op_rdata,
    // External bus
    output logic                              system_clock_output,
    output logic [ADDR_W-1:0]                 addr_out,
    output logic [FC_W-1:0]                   function_code_lines,
    output logic [1:0]                        transfer_length_lines,
    output logic                              read_write_select,
    output logic                              address_valid_strobe_n,
    output logic                              data_stable_strobe_n,
    output logic                              locked_cycle_flag_n,
    input  wire logic [15:0]                  data_in,
    output logic [15:0]                       data_out,
    output logic                              data_oe_n,
    input  wire logic                         port_width_ack_upper_n,
    input  wire logic                         port_width_ack_lower_n,
    input  wire logic                         bus_request_in_n,
    output logic                              bus_grant_out_n
);
    import ebc_pkg::*;

    bus_state_t        state_q;
    logic              sclk_q;
    logic              wr_q;
    logic              lock_q;
    logic              seen_q;
    logic [1:0]        port_q;
    logic [2:0]        rem_q;
    logic [ADDR_W-1:0] nxt_addr_q;
    logic [31:0]       wbuf_q;
    logic [31:0]       rdata_q;
    logic [2:0]        sync_v;
    logic [1:0]        ack_s;
    logic              ack_hit;
    logic              start;
    logic              fall_edge;
    logic [2:0]        nbytes;

    function automatic logic [31:0] align_wdata(input logic [1:0] sz, input logic [31:0] d);
        case (sz)
            SIZE_BYTE:  align_wdata = {d[7:0], 24'h000000};
            SIZE_WORD:  align_wdata = {d[15:0], 16'h0000};
            SIZE_THREE: align_wdata = {d[23:0], 8'h00};
            default:    align_wdata = d;
        endcase
    endfunction

    // Bytes moved by this cycle from port width, alignment and remainder
    function automatic logic [2:0] cycle_bytes(input logic [1:0] ack, input logic odd,
                                               input logic [2:0] rem);
        if (ack == ACK_PORT8) begin
            cycle_bytes = 3'h1;
        end else if (odd || rem == 3'h1) begin
            cycle_bytes = 3'h1;
        end else begin
            cycle_bytes = 3'h2;
        end
    endfunction

    input_sync #(
        .WIDTH      (3),
        .IDLE_LEVEL (RST_SYNC)
    ) input_sync_inst (
        .clk      (clk),
        .rst      (rst),
        .async_in ({port_width_ack_upper_n, port_width_ack_lower_n, bus_request_in_n}),
        .sync_out (sync_v)
    );

    assign ack_s     = sync_v[2:1];
    assign ack_hit   = ack_s != ACK_NONE;
    assign fall_edge = state_q == ST_S2 || state_q == ST_S4;
    assign nbytes    = cycle_bytes(port_q, addr_out[0], rem_q);
    // Only start on the edge that makes the output clock rise, so S0 is high
    assign req_ready = state_q == ST_IDLE && !sclk_q && bus_grant_out_n
                       && (!lock_q || req_lock);
    assign start     = req_valid && req_ready;
    assign op_done   = state_q == ST_S5 && rem_q == 3'h0;
    assign op_rdata  = rdata_q;
    assign system_clock_output = sclk_q;
    assign locked_cycle_flag_n = !lock_q;

    // Strobes decode straight from the state flop
    assign address_valid_strobe_n = !(state_q inside {ST_S1, ST_S2, ST_S3, ST_S4});
    assign data_stable_strobe_n   = wr_q ? !(state_q inside {ST_S3, ST_S4})
                                         : !(state_q inside {ST_S1, ST_S2, ST_S3, ST_S4});
    // Read level everywhere except a write cycle, so idle gaps never fight the target
    assign read_write_select = !(wr_q && state_q != ST_IDLE);
    assign data_oe_n = !(wr_q && state_q inside {ST_S2, ST_S3, ST_S4, ST_S5});

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'h0;
        end else begin
            sclk_q <= !sclk_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: state_q <= start ? ST_S0 : ST_IDLE;
                ST_S0:   state_q <= ST_S1;
                ST_S1:   state_q <= ST_S2;
                ST_S2:   state_q <= ST_S3;
                ST_S3:   state_q <= ST_S4;
                ST_S4:   state_q <= seen_q ? ST_S5 : ST_S3;
                ST_S5:   state_q <= rem_q != 3'h0 ? ST_S0 : ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Acknowledge sampled on the falling output edges that end S2 and S4, until first seen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_q <= 1'h0;
            port_q <= ACK_NONE;
        end else if (state_q == ST_S0) begin
            seen_q <= 1'h0;
        end else if (fall_edge && !seen_q && ack_hit) begin
            seen_q <= 1'h1;
            port_q <= ack_s;
        end
    end

    // Cycle set-up; outputs change only on entry to S0 so S5 keeps them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q                  <= 1'h0;
            addr_out              <= '0;
            function_code_lines   <= '0;
            transfer_length_lines <= SIZE_BYTE;
        end else if (start) begin
            wr_q                  <= req_write;
            addr_out              <= req_addr;
            transfer_length_lines <= req_size;
            if (!lock_q) begin
                function_code_lines <= req_fc;
            end
        end else if (state_q == ST_S5 && rem_q != 3'h0) begin
            addr_out              <= nxt_addr_q;
            transfer_length_lines <= size_code(rem_q);
        end
    end

    // Remaining byte bookkeeping and read data assembly
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rem_q      <= 3'h0;
            nxt_addr_q <= '0;
            wbuf_q     <= 32'h00000000;
            rdata_q    <= 32'h00000000;
        end else if (start) begin
            rem_q      <= size_bytes(req_size);
            nxt_addr_q <= req_addr;
            wbuf_q     <= align_wdata(req_size, req_wdata);
            rdata_q    <= 32'h00000000;
        end else if (state_q == ST_S4 && seen_q) begin
            rem_q      <= rem_q - nbytes;
            nxt_addr_q <= nxt_addr_q + ADDR_W'(nbytes);
            wbuf_q     <= nbytes == 3'h2 ? {wbuf_q[15:0], 16'h0000} : {wbuf_q[23:0], 8'h00};
            if (!wr_q) begin
                // Target still holds data here, strobes not yet negated
                if (nbytes == 3'h2) begin
                    rdata_q <= {rdata_q[15:0], data_in};
                end else if (port_q != ACK_PORT8 && addr_out[0]) begin
                    rdata_q <= {rdata_q[23:0], data_in[7:0]};
                end else begin
                    rdata_q <= {rdata_q[23:0], data_in[15:8]};
                end
            end
        end
    end

    // Write data placed at S2 and held through S5
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_out <= 16'h0000;
        end else if (state_q == ST_S1 && wr_q) begin
            if (addr_out[0] || rem_q == 3'h1) begin
                data_out <= {wbuf_q[31:24], wbuf_q[31:24]};
            end else begin
                data_out <= wbuf_q[31:16];
            end
        end
    end

    // Lock spans reads, idle gap and writes until released
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_q <= 1'h0;
        end else if (start && req_lock) begin
            lock_q <= 1'h1;
        end else if (state_q == ST_IDLE && lock_release) begin
            lock_q <= 1'h0;
        end
    end

    // Grant only between unlocked operations; an operation starting in the same cycle wins the tie
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_grant_out_n <= RST_STROBE_N;
        end else if (sync_v[0]) begin
            bus_grant_out_n <= 1'h1;
        end else if (state_q == ST_IDLE && !lock_q && !start) begin
            bus_grant_out_n <= 1'h0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    read_s0_drive_a: assert property (state_q == ST_S0 && !wr_q |->
        read_write_select && transfer_length_lines == size_code(rem_q))
        else $error("read S0 select or length wrong");
    read_strobes_a: assert property (state_q == ST_S0 && !wr_q |=>
        !address_valid_strobe_n && !data_stable_strobe_n)
        else $error("read S1 strobes not asserted");
    wait_loop_a: assert property (state_q == ST_S4 && !seen_q |=>
        state_q == ST_S3 ##1 state_q == ST_S4)
        else $error("wait state loop broken");
    zero_wait_a: assert property (state_q == ST_S2 && ack_hit |=>
        state_q == ST_S3 ##1 state_q == ST_S4 ##1 state_q == ST_S5)
        else $error("acknowledged cycle did not end");
    s5_hold_a: assert property (state_q == ST_S5 |-> address_valid_strobe_n
        && data_stable_strobe_n && $stable(addr_out) && $stable(transfer_length_lines)
        && $stable(function_code_lines))
        else $error("S5 strobes or hold wrong");
    write_ds_a: assert property (state_q == ST_S1 && wr_q |-> data_stable_strobe_n
        ##1 (data_stable_strobe_n && !data_oe_n) ##1 !data_stable_strobe_n)
        else $error("write data strobe timing wrong");
    write_data_hold_a: assert property (wr_q && state_q inside {ST_S3, ST_S4, ST_S5}
        |-> $stable(data_out) && !read_write_select)
        else $error("write data not held");
    lock_grant_a: assert property (!locked_cycle_flag_n |-> bus_grant_out_n)
        else $error("grant issued while locked");
    idle_read_a: assert property (state_q == ST_IDLE |-> read_write_select
        && address_valid_strobe_n)
        else $error("idle not reading");
    length_code_a: assert property (state_q == ST_S5 && rem_q != 3'h0 |=>
        transfer_length_lines == size_code($past(rem_q)))
        else $error("length code not updated");

    zero_wait_read_c: cover property (state_q == ST_S2 && !wr_q && ack_hit);
    write_wait_c: cover property (state_q == ST_S4 && wr_q && !seen_q);
    locked_write_c: cover property (lock_q && state_q == ST_S0 && wr_q);
    port8_multi_c: cover property (state_q == ST_S5 && port_q == ACK_PORT8 && rem_q != 3'h0);
endmodule

// [hdl/input_sync.sv]
`timescale 1ns/1ps
module input_sync #(
    parameter int              WIDTH      = 3,
    parameter logic [WIDTH-1:0] IDLE_LEVEL = '1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_q;

    // Second stage alone reads the first; resolves metastable levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_q <= IDLE_LEVEL;
            sync_out <= IDLE_LEVEL;
        end else begin
            stage1_q <= async_in;
            sync_out <= stage1_q;
        end
    end
endmodule

// [tb/bus_target_model.sv]
`timescale 1ns/1ps
module bus_target_model
    import ebc_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Bus from the sequencer
    input  wire logic [23:0] addr_out,
    input  wire logic [1:0]  transfer_length_lines,
    input  wire logic        read_write_select,
    input  wire logic        address_valid_strobe_n,
    input  wire logic        data_stable_strobe_n,
    input  wire logic [15:0] data_out,
    // Responses
    output logic [15:0]      data_in,
    output logic             port_width_ack_upper_n,
    output logic             port_width_ack_lower_n,
    // Behaviour chosen by the bench
    input  wire logic [1:0]  ack_code,
    input  wire logic [3:0]  ack_delay,
    input  wire logic        early_ack
);
    logic [7:0] mem [0:255];
    logic [3:0] count_q;
    logic       ack_on;
    logic [7:0] a;

    assign a = addr_out[7:0];
    // Acks drop as soon as the strobe negates, well inside one clock
    // Early mode is a fast decoder whose acks already stand before the strobe
    assign ack_on = (!address_valid_strobe_n || early_ack) && (count_q >= ack_delay);
    assign {port_width_ack_upper_n, port_width_ack_lower_n} =
        ack_on ? ack_code : ACK_NONE;

    initial data_in = 16'h5A5A;

    always @(posedge clk) begin
        count_q <= address_valid_strobe_n ? 4'h0 : count_q + {3'h0, count_q != 4'hF};
        // Lanes per port width and address bit 0; unused lane carries junk
        if (read_write_select && ack_on) begin
            if (ack_code == ACK_PORT8) begin
                data_in <= {mem[a], ~mem[a]};
            end else if (a[0]) begin
                data_in <= {~mem[a], mem[a]};
            end else begin
                data_in <= {mem[a], mem[a + 8'h01]};
            end
        end else begin
            // Released lines must not look like held data
            data_in <= ~data_in;
        end
        if (!read_write_select && ack_on && !data_stable_strobe_n) begin
            if (ack_code == ACK_PORT8) begin
                mem[a] <= data_out[15:8];
            end else if (a[0]) begin
                mem[a] <= data_out[7:0];
            end else begin
                mem[a] <= data_out[15:8];
                if (transfer_length_lines != SIZE_BYTE) begin
                    mem[a + 8'h01] <= data_out[7:0];
                end
            end
        end
    end
endmodule

// [tb/external_bus_cycle_sequencer_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
    $display("BAD %s expected %h seen %h", nm, exp, got); miscompares++; end end
module external_bus_cycle_sequencer_bench;
    import ebc_pkg::*;
    logic clk, rst, req_valid, req_ready, req_write, req_lock, lock_release, op_done;
    logic system_clock_output, read_write_select, address_valid_strobe_n, data_stable_strobe_n;
    logic locked_cycle_flag_n, data_oe_n, ack_u_n, ack_l_n, bus_request_in_n, bus_grant_out_n;
    logic [1:0] req_size, transfer_length_lines, ack_code;
    logic [23:0] req_addr, addr_out;
    logic [2:0] req_fc, function_code_lines;
    logic [31:0] req_wdata, op_rdata;
    logic [15:0] data_in, data_out;
    logic [3:0] ack_delay;
    logic [1:0] sizes [$];
    logic watch_lock, early_ack;
    int miscompares, checks_done, lock_gaps, grant_bad, op_cycles;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    external_bus_cycle_sequencer external_bus_cycle_sequencer_inst (
        .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_lock(req_lock), .req_size(req_size),
        .req_addr(req_addr), .req_fc(req_fc), .req_wdata(req_wdata),
        .lock_release(lock_release), .op_done(op_done), .op_rdata(op_rdata),
        .system_clock_output(system_clock_output), .addr_out(addr_out),
        .function_code_lines(function_code_lines), .transfer_length_lines(transfer_length_lines),
        .read_write_select(read_write_select), .address_valid_strobe_n(address_valid_strobe_n),
        .data_stable_strobe_n(data_stable_strobe_n), .locked_cycle_flag_n(locked_cycle_flag_n),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .port_width_ack_upper_n(ack_u_n), .port_width_ack_lower_n(ack_l_n),
        .bus_request_in_n(bus_request_in_n), .bus_grant_out_n(bus_grant_out_n));

    bus_target_model bus_target_model_inst (
        .clk(clk), .addr_out(addr_out), .transfer_length_lines(transfer_length_lines),
        .read_write_select(read_write_select), .address_valid_strobe_n(address_valid_strobe_n),
        .data_stable_strobe_n(data_stable_strobe_n), .data_out(data_out), .data_in(data_in),
        .port_width_ack_upper_n(ack_u_n), .port_width_ack_lower_n(ack_l_n),
        .ack_code(ack_code), .ack_delay(ack_delay), .early_ack(early_ack));

    // Length code seen at each address strobe, one entry per bus cycle
    always @(negedge address_valid_strobe_n) begin
        if (!rst) begin
            sizes.push_back(transfer_length_lines);
        end
    end

    always @(posedge clk) begin
        if (watch_lock) begin
            if (locked_cycle_flag_n !== 1'b0) lock_gaps++;
            if (bus_grant_out_n !== 1'b1) grant_bad++;
        end
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic run_op(input logic wr, input logic lk, input logic [1:0] sz,
                          input logic [23:0] ad, input logic [31:0] wd);
        int n;
        @(posedge clk); #1;
        {req_write, req_lock, req_size, req_addr, req_wdata} = {wr, lk, sz, ad, wd};
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(posedge clk); #1;
            n++;
        end
        @(posedge clk); #1;
        req_valid = 1'b0;
        n = 0;
        while (op_done !== 1'b1 && n < 400) begin
            @(posedge clk); #1;
            n++;
        end
        op_cycles = n;
        `CHK("op_done", 1'b1, op_done)
    endtask

    task automatic test_word_read;
        sizes.delete();
        // Acks already stand in S0, so the cycle runs with no wait state
        {ack_code, ack_delay, early_ack} = {ACK_PORT16, 4'h0, 1'b1};
        bus_target_model_inst.mem[8'h10] = 8'hA5;
        bus_target_model_inst.mem[8'h11] = 8'h3C;
        run_op(1'b0, 1'b0, SIZE_WORD, 24'h000010, 32'h0);
        early_ack = 1'b0;
        `CHK("op cycles", 5, op_cycles)
        `CHK("sysclk", 1'b0, system_clock_output)
        `CHK("addr", 24'h000010, addr_out)
        `CHK("fc", 3'h5, function_code_lines)
        `CHK("rw", 1'b1, read_write_select)
        `CHK("strobes", 2'h3, {address_valid_strobe_n, data_stable_strobe_n})
        `CHK("cycles", 1, sizes.size())
        `CHK("size", SIZE_WORD, sizes[0])
        @(posedge clk); #1;
        `CHK("rdata", 32'h0000A53C, op_rdata)
        $display("test word_read done");
    endtask

    task automatic test_long_write;
        logic [1:0] exp_sz [4];
        logic [7:0] exp_mem [4];
        exp_sz = '{SIZE_LONG, SIZE_THREE, SIZE_WORD, SIZE_BYTE};
        exp_mem = '{8'h11, 8'h22, 8'h33, 8'h44};
        sizes.delete();
        // Slow 8-bit target forces wait states on every cycle
        {ack_code, ack_delay} = {ACK_PORT8, 4'h6};
        run_op(1'b1, 1'b0, SIZE_LONG, 24'h000020, 32'h11223344);
        `CHK("rw", 1'b0, read_write_select)
        `CHK("oe", 1'b0, data_oe_n)
        `CHK("cycles", 4, sizes.size())
        for (int i = 0; i < 4; i++) begin
            `CHK("size", exp_sz[i], sizes[i])
            `CHK("mem", exp_mem[i], bus_target_model_inst.mem[8'h20 + i])
        end
        $display("test long_write done");
    endtask

    task automatic test_reserved_ack;
        {ack_code, ack_delay} = {2'h0, 4'h2};
        bus_target_model_inst.mem[8'h31] = 8'h5A;
        run_op(1'b0, 1'b0, SIZE_BYTE, 24'h000031, 32'h0);
        @(posedge clk); #1;
        `CHK("rdata", 32'h0000005A, op_rdata)
        $display("test reserved_ack done");
    endtask

    task automatic test_locked;
        int n;
        sizes.delete();
        {ack_code, ack_delay} = {ACK_PORT16, 4'h1};
        bus_target_model_inst.mem[8'h40] = 8'h0F;
        bus_target_model_inst.mem[8'h41] = 8'hF0;
        bus_request_in_n = 1'b0;
        run_op(1'b0, 1'b1, SIZE_WORD, 24'h000040, 32'h0);
        watch_lock = 1'b1;
        `CHK("lock", 1'b0, locked_cycle_flag_n)
        `CHK("rdata", 32'h00000FF0, op_rdata)
        // Codes of a request inside the lock must not reach the lines
        req_fc = 3'h2;
        run_op(1'b1, 1'b1, SIZE_WORD, 24'h000040, 32'h0000BEEF);
        watch_lock = 1'b0;
        req_fc = 3'h5;
        `CHK("fc lock", 3'h5, function_code_lines)
        `CHK("mem hi", 8'hBE, bus_target_model_inst.mem[8'h40])
        `CHK("mem lo", 8'hEF, bus_target_model_inst.mem[8'h41])
        `CHK("lock gaps", 0, lock_gaps)
        `CHK("grants", 0, grant_bad)
        `CHK("size same", sizes[0], sizes[1])
        @(posedge clk); #1;
        lock_release = 1'b1;
        @(posedge clk); #1;
        lock_release = 1'b0;
        n = 0;
        while (bus_grant_out_n !== 1'b0 && n < 20) begin
            @(posedge clk); #1;
            n++;
        end
        `CHK("grant", 1'b0, bus_grant_out_n)
        `CHK("unlocked", 1'b1, locked_cycle_flag_n)
        bus_request_in_n = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        `CHK("grant off", 1'b1, bus_grant_out_n)
        $display("test locked done");
    endtask

    initial begin
        {rst, req_valid, req_write, req_lock, lock_release, watch_lock} = 6'h20;
        {req_size, req_addr, req_wdata} = '0;
        req_fc = 3'h5;
        {ack_code, ack_delay, bus_request_in_n, early_ack} = {ACK_PORT16, 4'h0, 1'b1, 1'b0};
        repeat (2) @(posedge clk);
        #1;
        `CHK("rst strobes", 2'h3, {address_valid_strobe_n, data_stable_strobe_n})
        `CHK("rst rw lock", 2'h3, {read_write_select, locked_cycle_flag_n})
        rst = 1'b0;
        $display("test reset done");
        test_word_read();
        test_long_write();
        test_reserved_ack();
        test_locked();
        wrap_up();
    end

    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
endmodule
